// ==== ckg_ctrl.sv ====
// clock generation control: oscillator run control, clock select, peripheral gating
// assumes a byte register port on clk; sleep request comes from same-domain logic
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/1ps
`include "ckg_params.svh"

// Overview of operation
// - fast internal oscillator stop bit: 0 runs it, 1 halts it
// - sub stop bit runs/stops oscillator or gates external input; no effect as port
// - main stop bit runs/stops oscillator or gates external input; port mode unaffected
// - main select bit: 0 picks fast internal oscillator, 1 picks high-speed clock
// - main status reads 0 on internal oscillator, 1 on high-speed clock
// - cpu select bit: 0 routes main clock, 1 routes subsystem clock
// - cpu status reads 0 on main clock, 1 on subsystem clock
// - timer unit enables: 0 stops clock, blocks writes, holds reset
// - serial unit enables: 0 stops clock, blocks writes, holds reset
// - i2c unit enables: 0 stops clock, blocks writes, holds reset
// - converter enable: 0 stops clock, blocks writes, holds reset
// - calendar enable: 0 stops clock, blocks writes, holds reset
// - timekeeping select: 0 subsystem clock, 1 slow internal oscillator
// - in sleep on sub clock, gate bit 1 feeds only calendar and interval timer
// - main pin mode: 00/10 port, 01 oscillator, 11 external clock
// - sub pin mode: 00/10 port, 01 oscillator, 11 external clock
module ckg_ctrl
  import ckg_pkg::*;
#(
  parameter int SWITCH_CYC = `CKG_SWITCH_CYC
) (
  input  wire logic          clk,
  input  wire logic          resetn,
  input  wire logic [2:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  output logic      [7:0]    reg_rdata,
  input  wire logic          sleep_req,
  input  wire logic          unit_wr_req,
  input  wire logic [2:0]    unit_wr_sel,
  output logic               unit_wr_ok,
  output ckg_osc_ctrl_t      osc_ctrl,
  output logic               main_pins_port,
  output logic               sub_pins_port,
  output logic               main_src_high_speed,
  output logic               cpu_src_sub,
  output ckg_unit_vec_t      unit_clk_en,
  output ckg_unit_vec_t      unit_rst_n,
  output logic               timekeep_src_slow,
  output logic               periph_sub_clk_en
);

  // settle counter in the switch stage is eight bits wide
  if (SWITCH_CYC < 1 || SWITCH_CYC > 255) begin : g_bad_switch_cyc
    $error("ckg_ctrl: SWITCH_CYC out of range");
  end

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  logic [7:0]    osc_run_q;
  logic          main_sel_q;
  logic          cpu_sel_q;
  ckg_unit_vec_t gate_q;
  logic [7:0]    lp_ctrl_q;
  logic [7:0]    pin_mode_q;
  logic          main_stat;
  logic          cpu_stat;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_run_q <= `CKG_OSC_RUN_RST;
    end else if (reg_wr && reg_addr == `CKG_ADDR_OSC_RUN) begin
      osc_run_q <= reg_wdata & `CKG_OSC_RUN_MASK;
    end
  end

  // status bits ignore writes
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_sel_q <= 1'b0;
    end else if (reg_wr && reg_addr == `CKG_ADDR_SYS_SEL) begin
      main_sel_q <= reg_wdata[`CKG_MAIN_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      cpu_sel_q <= 1'b0;
    end else if (reg_wr && reg_addr == `CKG_ADDR_SYS_SEL) begin
      cpu_sel_q <= reg_wdata[`CKG_CPU_SEL_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gate_q <= ckg_unit_vec_t'(`CKG_PERI_GATE_RST);
    end else if (reg_wr && reg_addr == `CKG_ADDR_PERI_GATE) begin
      gate_q <= ckg_unit_vec_t'(reg_wdata);
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lp_ctrl_q <= `CKG_LP_CTRL_RST;
    end else if (reg_wr && reg_addr == `CKG_ADDR_LP_CTRL) begin
      lp_ctrl_q <= reg_wdata & `CKG_LP_CTRL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_mode_q <= `CKG_PIN_MODE_RST;
    end else if (reg_wr && reg_addr == `CKG_ADDR_PIN_MODE) begin
      pin_mode_q <= reg_wdata & `CKG_PIN_MODE_MASK;
    end
  end

  // ****************************************
  // clock switch status
  // ****************************************
  ckg_switch #(
    .SETTLE_CYC (SWITCH_CYC)
  ) u_main_sw (
    .clk    (clk),
    .rst_n  (rst_n_q),
    .sel    (main_sel_q),
    .status (main_stat)
  );

  ckg_switch #(
    .SETTLE_CYC (SWITCH_CYC)
  ) u_cpu_sw (
    .clk    (clk),
    .rst_n  (rst_n_q),
    .sel    (cpu_sel_q),
    .status (cpu_stat)
  );

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] rd_d;
  logic [7:0] rdata_q;

  always_comb begin
    rd_d = 8'h00;
    case (reg_addr)
      `CKG_ADDR_OSC_RUN:   rd_d = osc_run_q;
      `CKG_ADDR_SYS_SEL:   rd_d = {cpu_stat, cpu_sel_q, main_stat, main_sel_q, 4'h0};
      `CKG_ADDR_PERI_GATE: rd_d = gate_q;
      `CKG_ADDR_LP_CTRL:   rd_d = lp_ctrl_q;
      `CKG_ADDR_PIN_MODE:  rd_d = pin_mode_q;
      default:             rd_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd ? rd_d : 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

  // ****************************************
  // oscillator control
  // ****************************************
  ckg_pin_mode_t main_mode;
  ckg_pin_mode_t sub_mode;
  ckg_osc_ctrl_t osc_d;
  ckg_osc_ctrl_t osc_q;
  logic          main_port_q;
  logic          sub_port_q;

  assign main_mode = ckg_pin_mode_t'(pin_mode_q[`CKG_MAIN_MODE_LSB +: 2]);
  assign sub_mode  = ckg_pin_mode_t'(pin_mode_q[`CKG_SUB_MODE_LSB +: 2]);

  always_comb begin
    osc_d              = '0;
    osc_d.fast_int_run = !osc_run_q[`CKG_FAST_OSC_STOP_BIT];
    osc_d.main_osc_run = (main_mode == CKG_PIN_OSC) && !osc_run_q[`CKG_MAIN_OSC_STOP_BIT];
    osc_d.main_ext_en  = (main_mode == CKG_PIN_EXT) && !osc_run_q[`CKG_MAIN_OSC_STOP_BIT];
    osc_d.sub_osc_run  = (sub_mode == CKG_PIN_OSC) && !osc_run_q[`CKG_SUB_OSC_STOP_BIT];
    osc_d.sub_ext_en   = (sub_mode == CKG_PIN_EXT) && !osc_run_q[`CKG_SUB_OSC_STOP_BIT];
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_d;
    end
  end

  // pins stay ports through reset
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_port_q <= 1'b1;
      sub_port_q  <= 1'b1;
    end else begin
      main_port_q <= main_mode[0] == 1'b0;
      sub_port_q  <= sub_mode[0] == 1'b0;
    end
  end

  assign osc_ctrl       = osc_q;
  assign main_pins_port = main_port_q;
  assign sub_pins_port  = sub_port_q;

  // ****************************************
  // clock selection outputs
  // ****************************************
  logic main_src_q;
  logic cpu_src_q;
  logic tk_src_q;
  logic psub_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      main_src_q <= 1'b0;
      cpu_src_q  <= 1'b0;
    end else begin
      main_src_q <= main_stat;
      cpu_src_q  <= cpu_stat;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tk_src_q <= 1'b0;
    end else begin
      tk_src_q <= lp_ctrl_q[`CKG_TK_SEL_BIT];
    end
  end

  // only a sleeping, sub-clocked cpu may drop the peripheral sub clock
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      psub_q <= 1'b1;
    end else begin
      psub_q <= !(sleep_req && cpu_stat && lp_ctrl_q[`CKG_LP_GATE_BIT]);
    end
  end

  assign main_src_high_speed = main_src_q;
  assign cpu_src_sub         = cpu_src_q;
  assign timekeep_src_slow   = tk_src_q;
  assign periph_sub_clk_en   = psub_q;

  // ****************************************
  // peripheral gating
  // ****************************************
  ckg_unit_vec_t clk_en_q;
  ckg_unit_vec_t urst_q;
  logic          wr_ok_q;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_unit
      always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          clk_en_q[gi] <= 1'b0;
          urst_q[gi]   <= 1'b0;
        end else begin
          clk_en_q[gi] <= gate_q[gi];
          urst_q[gi]   <= gate_q[gi];
        end
      end
    end
  endgenerate

  // unit register writes pass only while the unit is enabled
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_ok_q <= 1'b0;
    end else begin
      wr_ok_q <= unit_wr_req && gate_q[unit_wr_sel];
    end
  end

  assign unit_clk_en = clk_en_q;
  assign unit_rst_n  = urst_q;
  assign unit_wr_ok  = wr_ok_q;

endmodule

// ==== ckg_ctrl_chk.sv ====
// assertions for the clock controller, bound to ckg_ctrl
// assumes one clock domain and one select write per switch
`timescale 1ns/1ps
`include "ckg_params.svh"
module ckg_ctrl_chk
  import ckg_pkg::*;
#(
  parameter int SWITCH_CYC = `CKG_SWITCH_CYC
) (
  input logic          clk,
  input logic          resetn,
  input logic [2:0]    reg_addr,
  input logic [7:0]    reg_wdata,
  input logic          reg_wr,
  input logic          sleep_req,
  input logic          unit_wr_req,
  input logic [2:0]    unit_wr_sel,
  input logic          unit_wr_ok,
  input ckg_osc_ctrl_t osc_ctrl,
  input logic          main_pins_port,
  input logic          sub_pins_port,
  input logic          main_src_high_speed,
  input logic          cpu_src_sub,
  input ckg_unit_vec_t unit_clk_en,
  input ckg_unit_vec_t unit_rst_n,
  input logic          timekeep_src_slow,
  input logic          periph_sub_clk_en
);
  localparam int CPU_LAG = SWITCH_CYC + 3;
  logic       msel_q;
  logic [8:0] mcnt_q;
  logic [7:0] en_v;
  assign en_v = unit_clk_en;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ****
  // main select shadow, cycles since it changed
  // ****
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msel_q <= 1'b0;
      mcnt_q <= 9'h000;
    end else if (reg_wr && reg_addr == 3'h1 && reg_wdata[4] != msel_q) begin
      msel_q <= reg_wdata[4];
      mcnt_q <= 9'h000;
    end else if (mcnt_q != 9'h1ff) begin
      mcnt_q <= mcnt_q + 9'h001;
    end
  end
  a_main_stat_when: assert property ($changed(main_src_high_speed) |->
    main_src_high_speed == msel_q && mcnt_q == SWITCH_CYC + 2) else $error("main status moved early");
  a_main_stat_done: assert property ((mcnt_q == SWITCH_CYC + 1 &&
    main_src_high_speed != msel_q) |=> main_src_high_speed == msel_q) else $error("main switch late");
  a_cpu_stat_cause: assert property ($rose(cpu_src_sub) |->
    $past(reg_wr && reg_addr == 3'h1 && reg_wdata[6], CPU_LAG)) else $error("cpu status timing");
  a_fast_osc_run: assert property (reg_wr && reg_addr == 3'h0 |=> ##1
    osc_ctrl.fast_int_run == !$past(reg_wdata[0], 2)) else $error("fast osc run wrong");
  a_gate_follow: assert property (reg_wr && reg_addr == 3'h2 |=> ##1
    (en_v == $past(reg_wdata, 2) && unit_rst_n == unit_clk_en)) else $error("gate wrong");
  a_unit_wr_gate: assert property (unit_wr_ok ==
    ($past(unit_wr_req) && en_v[$past(unit_wr_sel)])) else $error("unit write gate wrong");
  a_timekeep_sel: assert property (reg_wr && reg_addr == 3'h3 |=> ##1
    timekeep_src_slow == $past(reg_wdata[4], 2)) else $error("timekeep select wrong");
  a_awake_sub_on: assert property (!sleep_req |=> periph_sub_clk_en)
    else $error("sub clock gated while awake");
  a_pin_port_mode: assert property (reg_wr && reg_addr == 3'h4 |=> ##1
    (main_pins_port == !$past(reg_wdata[6], 2) && sub_pins_port == !$past(reg_wdata[4], 2)))
    else $error("pin mode wrong");
  c_main_switch: cover property ($rose(main_src_high_speed));
  c_sleep_gated: cover property ($fell(periph_sub_clk_en));
  c_unit_refused: cover property (unit_wr_req && !en_v[unit_wr_sel]);
endmodule

bind ckg_ctrl ckg_ctrl_chk #(.SWITCH_CYC(SWITCH_CYC)) ckg_ctrl_chk_i (
  .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .sleep_req(sleep_req), .unit_wr_req(unit_wr_req),
  .unit_wr_sel(unit_wr_sel), .unit_wr_ok(unit_wr_ok), .osc_ctrl(osc_ctrl),
  .main_pins_port(main_pins_port), .sub_pins_port(sub_pins_port),
  .main_src_high_speed(main_src_high_speed), .cpu_src_sub(cpu_src_sub),
  .unit_clk_en(unit_clk_en), .unit_rst_n(unit_rst_n),
  .timekeep_src_slow(timekeep_src_slow), .periph_sub_clk_en(periph_sub_clk_en)
);

// ==== ckg_ctrl_test.sv ====
// self-checking bench for the clock controller
// assumes ckg_params.svh, ckg_pkg and ckg_ctrl_chk compiled first
`timescale 1ns/1ps
module ckg_ctrl_test
  import ckg_pkg::*;
;
  localparam int SW = 2;
  logic          clk;
  logic          resetn;
  logic [2:0]    reg_addr, unit_wr_sel;
  logic [7:0]    reg_wdata, reg_rdata, v, p;
  logic          reg_wr, reg_rd, sleep_req, unit_wr_req, unit_wr_ok;
  logic          pins_m, pins_s, src_hs, src_sub, tk_slow, psub_en;
  ckg_osc_ctrl_t osc;
  ckg_unit_vec_t cen, urst_n;
  int            n_errors = 0;
  int            compares = 0;

  ckg_ctrl #(.SWITCH_CYC(SW)) ckg_ctrl_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
    .unit_wr_req(unit_wr_req), .unit_wr_sel(unit_wr_sel), .unit_wr_ok(unit_wr_ok),
    .osc_ctrl(osc), .main_pins_port(pins_m), .sub_pins_port(pins_s),
    .main_src_high_speed(src_hs), .cpu_src_sub(src_sub), .unit_clk_en(cen),
    .unit_rst_n(urst_n), .timekeep_src_slow(tk_slow), .periph_sub_clk_en(psub_en)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****
  // expectation, compare and bus tasks
  // ****
  function automatic logic [7:0] exp_osc(input logic [3:0] m, input logic [7:0] d);
    return {1'b0, !m[2], !m[0], m[3:2] == 2'b01 && !d[7], m[3:2] == 2'b11 && !d[7],
            m[1:0] == 2'b01 && !d[6], m[1:0] == 2'b11 && !d[6], !d[0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, e, reg_rdata);
  endtask
  task automatic unit(input logic [2:0] s, input logic e);
    @(posedge clk);
    unit_wr_req <= 1'b1;
    unit_wr_sel <= s;
    @(posedge clk);
    unit_wr_req <= 1'b0;
    #1 chk("unit_wr_ok", {7'h0, e}, {7'h0, unit_wr_ok});
  endtask
  task automatic wait2();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(53864));
    {resetn, reg_wr, reg_rd, sleep_req, unit_wr_req} = 5'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    unit_wr_sel = 3'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("osc_rst", exp_osc(4'h0, 8'hc0), {1'b0, pins_m, pins_s, osc});
    for (int a = 0; a < 8; a++) rd(3'(a), (a == 0) ? 8'hc0 : 8'h00, "reset");
    for (int i = 0; i < 16; i++) begin
      p = {4'(i), 4'($urandom)};
      v = 8'($urandom);
      wr(3'h4, p);
      wr(3'h0, v);
      wait2();
      chk("osc", exp_osc(p[7:4], v), {1'b0, pins_m, pins_s, osc});
      rd(3'h0, v & 8'hc1, "osc_run");
      rd(3'h4, p & 8'hf0, "pin_mode");
    end
    wr(3'h1, 8'hf0);
    rd(3'h1, 8'h50, "sel_early");
    repeat (SW + 2) @(posedge clk);
    rd(3'h1, 8'hf0, "sel_done");
    chk("src", 8'h03, {6'h0, src_hs, src_sub});
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
      wr(3'h2, v);
      wait2();
      chk("clk_en", v, cen);
      chk("rst_n", v, urst_n);
      rd(3'h2, v, "gate");
      for (int u = 0; u < 8; u++) unit(3'(u), v[u]);
    end
    for (int j = 0; j < 4; j++) begin
      v = {j[1], 2'b00, j[0], 4'($urandom)};
      @(posedge clk) sleep_req <= 1'b1;
      wr(3'h3, v);
      wait2();
      chk("lp", {6'h0, v[4], !v[7]}, {6'h0, tk_slow, psub_en});
      rd(3'h3, v & 8'h90, "lp_ctrl");
      @(posedge clk) sleep_req <= 1'b0;
      wait2();
      chk("awake", 8'h01, {7'h0, psub_en});
    end
    // back on the main clock: sleep must not gate the sub clock
    wr(3'h1, 8'h00);
    @(posedge clk) sleep_req <= 1'b1;
    repeat (SW + 2) @(posedge clk);
    rd(3'h1, 8'h00, "sel_back");
    chk("src_back", 8'h00, {6'h0, src_hs, src_sub});
    chk("main_psub", 8'h01, {7'h0, psub_en});
    @(posedge clk) sleep_req <= 1'b0;
    // select undone before it settles leaves the status alone
    wr(3'h1, 8'h10);
    wr(3'h1, 8'h00);
    repeat (SW + 2) @(posedge clk);
    rd(3'h1, 8'h00, "sel_cancel");
    chk("src_cancel", 8'h00, {6'h0, src_hs, src_sub});
    wr(3'h5, 8'hff);
    rd(3'h5, 8'h00, "unmapped");
    wr(3'h2, 8'h00);
    end_of_test();
  end
endmodule

// ==== ckg_params.svh ====
// clock control constants: register indices, field positions, reset values, timing counts
// assumes a plain byte register port addressed by small indices
`ifndef CKG_PARAMS_SVH
`define CKG_PARAMS_SVH

// ****************************************
// register indices
// ****************************************
`define CKG_ADDR_OSC_RUN      3'h0
`define CKG_ADDR_SYS_SEL      3'h1
`define CKG_ADDR_PERI_GATE    3'h2
`define CKG_ADDR_LP_CTRL      3'h3
`define CKG_ADDR_PIN_MODE     3'h4

// ****************************************
// field positions
// ****************************************
`define CKG_FAST_OSC_STOP_BIT 0
`define CKG_SUB_OSC_STOP_BIT  6
`define CKG_MAIN_OSC_STOP_BIT 7
`define CKG_MAIN_SEL_BIT      4
`define CKG_MAIN_STAT_BIT     5
`define CKG_CPU_SEL_BIT       6
`define CKG_CPU_STAT_BIT      7
`define CKG_TK_SEL_BIT        4
`define CKG_LP_GATE_BIT       7
`define CKG_SUB_MODE_LSB      4
`define CKG_MAIN_MODE_LSB     6

// ****************************************
// reset values and writable masks
// ****************************************
`define CKG_OSC_RUN_RST       8'hc0
`define CKG_OSC_RUN_MASK      8'hc1
`define CKG_SYS_SEL_RST       8'h00
`define CKG_PERI_GATE_RST     8'h00
`define CKG_LP_CTRL_RST       8'h00
`define CKG_LP_CTRL_MASK      8'h90
`define CKG_PIN_MODE_RST      8'h00
`define CKG_PIN_MODE_MASK     8'hf0

// ****************************************
// switch settle time
// ****************************************
`define CKG_SWITCH_NS         200
`define CKG_CLK_NS            40
`define CKG_SWITCH_CYC        ((`CKG_SWITCH_NS + `CKG_CLK_NS - 1) / `CKG_CLK_NS)

`endif

// ==== ckg_pkg.sv ====
// clock control types shared by the clock controller and its switch stage
// assumes ckg_params.svh is compiled alongside
package ckg_pkg;

  typedef enum logic [1:0] {
    CKG_PIN_PORT0 = 2'b00,
    CKG_PIN_OSC   = 2'b01,
    CKG_PIN_PORT1 = 2'b10,
    CKG_PIN_EXT   = 2'b11
  } ckg_pin_mode_t;

  typedef struct packed {
    logic main_osc_run;
    logic main_ext_en;
    logic sub_osc_run;
    logic sub_ext_en;
    logic fast_int_run;
  } ckg_osc_ctrl_t;

  typedef struct packed {
    logic calendar;
    logic i2c1;
    logic converter;
    logic i2c0;
    logic serial1;
    logic serial0;
    logic timer1;
    logic timer0;
  } ckg_unit_vec_t;

endpackage

// ==== ckg_switch.sv ====
// one clock-source switch: requested select followed by status after a settle time
// assumes the selected source is running; same clock domain as the caller
`timescale 1ns/1ps
`include "ckg_params.svh"

module ckg_switch
  import ckg_pkg::*;
#(
  parameter int SETTLE_CYC = `CKG_SWITCH_CYC
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic sel,
  output logic      status
);

  // settle counter is eight bits wide
  if (SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_bad_settle
    $error("ckg_switch: SETTLE_CYC out of range");
  end

  typedef enum logic [0:0] {
    CKG_SW_IDLE = 1'b0,
    CKG_SW_WAIT = 1'b1
  } ckg_sw_state_t;

  ckg_sw_state_t state_q;
  logic [7:0]    cnt_q;
  logic          status_q;

  // status follows only after the switch has settled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= CKG_SW_IDLE;
      cnt_q    <= 8'h00;
      status_q <= 1'b0;
    end else begin
      case (state_q)
        CKG_SW_IDLE: begin
          if (sel != status_q) begin
            state_q <= CKG_SW_WAIT;
            cnt_q   <= 8'(SETTLE_CYC - 1);
          end
        end
        CKG_SW_WAIT: begin
          if (sel == status_q) begin
            state_q <= CKG_SW_IDLE;
          end else if (cnt_q == 8'h00) begin
            status_q <= sel;
            state_q  <= CKG_SW_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: state_q <= CKG_SW_IDLE;
      endcase
    end
  end

  assign status = status_q;

endmodule
